// ==== rtl/device_config_and_id_regs.v ====
// configuration and identification register bank with wishbone slave
// Functional notes
// - usb id pin owned by usb controller when owner bit is one, else port logic
// - usb module disable forces usb id pin back to port control
// - pin remap lock one allows a single remap change, zero unlimited
// - module disable lock one allows a single change, zero unlimited
// - permission group lock one allows a single change, zero unlimited
// - ethernet pin set bit one selects default pins, zero alternate pins
// - parts without alternate ethernet pins ignore the pin set bit
// - media interface bit one selects mii, zero selects rmii
// - 16-bit user value readable by serial programming port and jtag
// - id word read-only: revision in 31..28, part identifier in 27..0
// - two read-only 32-bit unique serial number words, index 0 and 1
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "device_config_id_map.vh"
module device_config_and_id_regs #(
   parameter HAS_ALT_ETHERNET_PINS = 1,
   // arbitrary neutral identification values
   parameter [3:0] SILICON_REVISION = 4'h1,
   parameter [27:0] PART_IDENTIFIER = 28'h000_0001
) (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // wishbone slave
   input wire wbCyc,
   input wire wbStb,
   input wire wbWe,
   input wire [7:0] wbAdr,
   input wire [3:0] wbSel,
   input wire [31:0] wbDatIn,
   output reg [31:0] wbDatOut,
   output reg wbAck,
   // nonvolatile storage values
   input wire [31:0] nvConfigWordThree,
   input wire [31:0] nvSerialWord0,
   input wire [31:0] nvSerialWord1,
   // side-band control
   input wire usbModuleDisable,
   input wire usbIdPinIn,
   // pin and mode steering
   output reg usbIdPinOwner,
   output reg ethernetPinSetSelect,
   output reg mediaInterfaceSelect,
   output reg [15:0] userValueField,
   output reg pinRemapLocked,
   output reg moduleDisableLocked,
   output reg permGroupLocked,
   output reg usbIdPinToUsb,
   output reg usbIdPinToPort
);
   localparam ST_CAPTURE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_ACK = 2'd2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [2:0] reconfigReq;
   reg [1:0] storeIndex;
   reg addrMapped_reg;
   reg readStore_reg;
   reg [31:0] lockWord_reg;
   wire [31:0] storeData;
   wire [2:0] lockState;
   wire [31:0] configWord;
   wire [31:0] idWord;
   wire [2:0] oneWayMode;
   wire request;
   // address decode of the request that is being taken
   wire takeRequest;
   wire captureCycle;
   wire hitStoreWindow;
   wire hitAligned;
   wire hitLockStatus;
   wire hitLockControl;
   wire lockControlWrite;
   wire [31:0] lockStatusWord;
   // derived pin and mode steering
   wire usbOwnerBit;
   wire usbToController;
   wire usbToPort;
   wire ethernetSetNext;

   // reserved positions forced to one whatever storage holds
   assign configWord = (nvConfigWordThree & `RESERVED_ONES_MASK) | `RESERVED_ONES_BITS;
   assign idWord = {SILICON_REVISION, PART_IDENTIFIER};
   assign request = wbCyc & wbStb & ~wbAck;

   config_word_store #(
      .WIDTH(32)
   ) store (
      .clk_sys(clk_sys),
      .rst(rst),
      .loadEn(state_reg == ST_CAPTURE),
      .loadWord0(configWord),
      .loadWord1(idWord),
      .loadWord2(nvSerialWord0),
      .loadWord3(nvSerialWord1),
      .readIndex(storeIndex),
      .readData(storeData)
   );

   assign oneWayMode[`CTRL_BIT_PIN_REMAP] = lockWord_reg[`BIT_PIN_REMAP_LOCK];
   assign oneWayMode[`CTRL_BIT_MODULE_DISABLE] = lockWord_reg[`BIT_MODULE_DISABLE_LOCK];
   assign oneWayMode[`CTRL_BIT_PERM_GROUP] = lockWord_reg[`BIT_PERM_GROUP_LOCK];

   one_way_lock #(
      .GROUPS(3)
   ) locks (
      .clk_sys(clk_sys),
      .rst(rst),
      .oneWayMode(oneWayMode),
      .reconfigReq(reconfigReq),
      .lockedOut(lockState)
   );

   // decode of the request presented while the bank is idle
   assign takeRequest = (state_reg == ST_RUN) & request;
   assign captureCycle = (state_reg == ST_CAPTURE);
   assign hitStoreWindow = (wbAdr[`PAGE_MSB:`PAGE_LSB] == `STORE_PAGE);
   assign hitAligned = (wbAdr[`MAPPED_MSB:`MAPPED_LSB] == `MAPPED_PAGE) &&
      (wbAdr[`ALIGN_MSB:`ALIGN_LSB] == `ALIGN_WORD);
   assign hitLockStatus = (wbAdr == {`OFS_HIGH_ZERO, `OFS_LOCK_STATUS});
   assign hitLockControl = (wbAdr == {`OFS_HIGH_ZERO, `OFS_LOCK_CONTROL});
   assign lockControlWrite = takeRequest & wbWe & wbSel[`SEL_LOCK_BYTE] & hitLockControl;
   assign lockStatusWord = {`LOCK_STATUS_PAD, lockState};

   // reconfiguration strobes come from writes to the lock control word;
   // a group that is already locked never sees another strobe
   always @* begin
      reconfigReq = `NO_GROUPS;
      if (lockControlWrite) begin
         reconfigReq = wbDatIn[`CTRL_BIT_PERM_GROUP:`CTRL_BIT_PIN_REMAP] & ~lockState;
      end
   end

   // store read index follows the word address of the request
   always @* begin
      storeIndex = wbAdr[`STORE_INDEX_MSB:`ADDR_INDEX_LSB];
   end

   // capture once, then alternate between taking a request and answering it
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_CAPTURE: begin
            state_next = ST_RUN;
         end
         ST_RUN: begin
            if (request) begin
               state_next = ST_ACK;
            end
         end
         ST_ACK: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_CAPTURE;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= ST_CAPTURE;
      end else begin
         state_reg <= state_next;
      end
   end

   // configuration is taken once, in the first cycle after reset
   always @(posedge clk_sys) begin
      if (rst) begin
         lockWord_reg <= `WORD_ZERO;
      end else if (captureCycle) begin
         lockWord_reg <= configWord;
      end
   end

   // the request is decoded on the edge that takes it, answered one cycle later
   always @(posedge clk_sys) begin
      if (rst) begin
         readStore_reg <= 1'b0;
         addrMapped_reg <= 1'b0;
      end else if (takeRequest) begin
         readStore_reg <= hitStoreWindow;
         addrMapped_reg <= hitAligned;
      end
   end

   // acknowledge is a single-cycle pulse per request
   always @(posedge clk_sys) begin
      if (rst) begin
         wbAck <= 1'b0;
      end else begin
         wbAck <= (state_reg == ST_ACK);
      end
   end

   // writes never alter the stored words; they are answered like reads
   always @(posedge clk_sys) begin
      if (rst) begin
         wbDatOut <= `WORD_ZERO;
      end else if (state_reg == ST_ACK) begin
         if (readStore_reg && addrMapped_reg) begin
            wbDatOut <= storeData;
         end else if (addrMapped_reg && hitLockStatus) begin
            wbDatOut <= lockStatusWord;
         end else begin
            wbDatOut <= `UNMAPPED_READ_VALUE;
         end
      end
   end

   // steering decisions from the captured word
   assign usbOwnerBit = lockWord_reg[`BIT_USB_ID_PIN_OWNER];
   assign usbToController = usbOwnerBit & ~usbModuleDisable;
   assign usbToPort = ~usbOwnerBit | usbModuleDisable;
   // without alternate pins the default set is always used
   assign ethernetSetNext = (HAS_ALT_ETHERNET_PINS != 0) ?
      lockWord_reg[`BIT_ETHERNET_PIN_SET] : `ETHERNET_DEFAULT_SET;

   // usb id pin ownership as programmed
   always @(posedge clk_sys) begin
      if (rst) begin
         usbIdPinOwner <= 1'b0;
      end else begin
         usbIdPinOwner <= usbOwnerBit;
      end
   end

   // media interface: one is mii, zero is rmii
   always @(posedge clk_sys) begin
      if (rst) begin
         mediaInterfaceSelect <= 1'b0;
      end else begin
         mediaInterfaceSelect <= lockWord_reg[`BIT_MEDIA_INTERFACE];
      end
   end

   // ethernet pin set: one is the default set
   always @(posedge clk_sys) begin
      if (rst) begin
         ethernetPinSetSelect <= 1'b0;
      end else begin
         ethernetPinSetSelect <= ethernetSetNext;
      end
   end

   // user value for the programming and test ports
   always @(posedge clk_sys) begin
      if (rst) begin
         userValueField <= `USER_VALUE_ZERO;
      end else begin
         userValueField <= lockWord_reg[`USER_VALUE_MSB:`USER_VALUE_LSB];
      end
   end

   // lock state of the pin remap group
   always @(posedge clk_sys) begin
      if (rst) begin
         pinRemapLocked <= 1'b0;
      end else begin
         pinRemapLocked <= lockState[`CTRL_BIT_PIN_REMAP];
      end
   end

   // lock state of the module disable group
   always @(posedge clk_sys) begin
      if (rst) begin
         moduleDisableLocked <= 1'b0;
      end else begin
         moduleDisableLocked <= lockState[`CTRL_BIT_MODULE_DISABLE];
      end
   end

   // lock state of the permission group
   always @(posedge clk_sys) begin
      if (rst) begin
         permGroupLocked <= 1'b0;
      end else begin
         permGroupLocked <= lockState[`CTRL_BIT_PERM_GROUP];
      end
   end

   // usb id pin level toward the usb controller
   always @(posedge clk_sys) begin
      if (rst) begin
         usbIdPinToUsb <= 1'b0;
      end else begin
         usbIdPinToUsb <= usbIdPinIn & usbToController;
      end
   end

   // usb id pin level toward the port logic
   always @(posedge clk_sys) begin
      if (rst) begin
         usbIdPinToPort <= 1'b0;
      end else begin
         usbIdPinToPort <= usbIdPinIn & usbToPort;
      end
   end
endmodule

// ==== rtl/device_config_id_map.vh ====
// register offsets, field positions and reset values of the configuration and id bank
`ifndef DEVICE_CONFIG_ID_MAP_VH
`define DEVICE_CONFIG_ID_MAP_VH
`define OFS_CONFIG_WORD_THREE 4'h0
`define OFS_REVISION_PART_ID 4'h4
`define OFS_UNIQUE_SERIAL_0 4'h8
`define OFS_UNIQUE_SERIAL_1 4'hC
`define OFS_LOCK_STATUS 5'h10
`define OFS_LOCK_CONTROL 5'h14
`define ADDR_INDEX_MSB 4
`define ADDR_INDEX_LSB 2
`define BIT_USB_ID_PIN_OWNER 30
`define BIT_PIN_REMAP_LOCK 29
`define BIT_MODULE_DISABLE_LOCK 28
`define BIT_PERM_GROUP_LOCK 27
`define BIT_ETHERNET_PIN_SET 25
`define BIT_MEDIA_INTERFACE 24
`define USER_VALUE_MSB 15
`define USER_VALUE_LSB 0
`define REVISION_MSB 31
`define REVISION_LSB 28
`define PART_ID_MSB 27
`define PART_ID_LSB 0
`define RESERVED_ONES_MASK 32'h7B00_FFFF
`define RESERVED_ONES_BITS 32'h84FF_0000
`define WORD_ZERO 32'h0000_0000
`define CTRL_BIT_PIN_REMAP 0
`define CTRL_BIT_MODULE_DISABLE 1
`define CTRL_BIT_PERM_GROUP 2
`define CTRL_BIT_USB_DISABLE 3
`define UNMAPPED_READ_VALUE 32'h0000_0000
`define PAGE_MSB 7
`define PAGE_LSB 4
`define STORE_PAGE 4'h0
`define MAPPED_MSB 7
`define MAPPED_LSB 5
`define MAPPED_PAGE 3'b000
`define ALIGN_MSB 1
`define ALIGN_LSB 0
`define ALIGN_WORD 2'b00
`define OFS_HIGH_ZERO 3'b000
`define STORE_INDEX_MSB 3
`define SEL_LOCK_BYTE 0
`define NO_GROUPS 3'b000
`define LOCK_STATUS_PAD 29'h0000_0000
`define USER_VALUE_ZERO 16'h0000
`define ETHERNET_DEFAULT_SET 1'b1
`endif

// ==== rtl/config_word_store.v ====
// four-word read-only store loaded from nonvolatile values, registered read port
`timescale 1ns/10ps
module config_word_store #(
   parameter WIDTH = 32
) (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // load side
   input wire loadEn,
   input wire [WIDTH-1:0] loadWord0,
   input wire [WIDTH-1:0] loadWord1,
   input wire [WIDTH-1:0] loadWord2,
   input wire [WIDTH-1:0] loadWord3,
   // read side
   input wire [1:0] readIndex,
   output reg [WIDTH-1:0] readData
);
   reg [WIDTH-1:0] mem0_reg;
   reg [WIDTH-1:0] mem1_reg;
   reg [WIDTH-1:0] mem2_reg;
   reg [WIDTH-1:0] mem3_reg;

   always @(posedge clk_sys) begin
      if (rst) begin
         mem0_reg <= {WIDTH{1'b0}};
         mem1_reg <= {WIDTH{1'b0}};
         mem2_reg <= {WIDTH{1'b0}};
         mem3_reg <= {WIDTH{1'b0}};
         readData <= {WIDTH{1'b0}};
      end else begin
         if (loadEn) begin
            mem0_reg <= loadWord0;
            mem1_reg <= loadWord1;
            mem2_reg <= loadWord2;
            mem3_reg <= loadWord3;
         end
         case (readIndex)
            2'd0: readData <= mem0_reg;
            2'd1: readData <= mem1_reg;
            2'd2: readData <= mem2_reg;
            default: readData <= mem3_reg;
         endcase
      end
   end
endmodule

// ==== rtl/one_way_lock.v ====
// per-group reconfiguration lock: one-way groups refuse after their first change
`timescale 1ns/10ps
module one_way_lock #(
   parameter GROUPS = 3
) (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // policy and requests
   input wire [GROUPS-1:0] oneWayMode,
   input wire [GROUPS-1:0] reconfigReq,
   // state
   output reg [GROUPS-1:0] lockedOut
);
   genvar g;
   generate
      for (g = 0; g < GROUPS; g = g + 1) begin : grp
         always @(posedge clk_sys) begin
            if (rst) begin
               lockedOut[g] <= 1'b0;
            end else if (reconfigReq[g] && oneWayMode[g]) begin
               lockedOut[g] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule

// ==== bench/device_config_and_id_regs_assertions.sv ====
// concurrent checks on the ports of the configuration and id register bank
`timescale 1ns/10ps
module device_config_checks #(
   parameter [3:0] SILICON_REVISION = 4'h1,
   parameter [27:0] PART_IDENTIFIER = 28'h000_0001
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // bus
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatOut,
   input wire logic wbAck,
   // usb id and configuration
   input wire logic usbIdPinIn,
   input wire logic usbModuleDisable,
   input wire logic usbIdPinOwner,
   input wire logic usbIdPinToUsb,
   input wire logic usbIdPinToPort,
   input wire logic [15:0] userValueField
);
   reg [1:0] upCnt;
   wire upOk = upCnt == 2'h3;
   wire rdAck = wbAck && !wbWe;
   // outputs are trusted only once capture and derivation have settled
   always @(posedge clk_sys) begin
      if (rst)
         upCnt <= 2'h0;
      else if (!upOk)
         upCnt <= upCnt + 2'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ack_one_cycle_a: assert property (wbAck |=> !wbAck)
      else $error("ack held too long");
   ack_bounded_a: assert property ((upOk && wbCyc && wbStb && !wbAck) |-> ##[1:2] wbAck)
      else $error("ack missing");
   ack_needs_request_a: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   usb_owner_route_a: assert property (
      (upOk && usbIdPinOwner && !usbModuleDisable && usbIdPinIn) |=> usbIdPinToUsb && !usbIdPinToPort)
      else $error("usb id pin not given to usb");
   usb_disable_route_a: assert property (
      (upOk && usbModuleDisable && usbIdPinIn) |=> usbIdPinToPort && !usbIdPinToUsb)
      else $error("usb id pin not back at port");
   id_word_read_a: assert property (
      (rdAck && wbAdr == 8'h04) |-> wbDatOut == {SILICON_REVISION, PART_IDENTIFIER})
      else $error("id word wrong");
   reserved_ones_a: assert property (
      (rdAck && wbAdr == 8'h00) |-> (wbDatOut & 32'h84FF_0000) == 32'h84FF_0000)
      else $error("reserved bits not one");
   user_value_read_a: assert property (
      (rdAck && wbAdr == 8'h00) |-> wbDatOut[15:0] == userValueField)
      else $error("user value read wrong");
   config_held_a: assert property (
      upOk |=> $stable(userValueField) && $stable(usbIdPinOwner))
      else $error("configuration changed");
endmodule
bind device_config_and_id_regs device_config_checks #(
   .SILICON_REVISION(SILICON_REVISION),
   .PART_IDENTIFIER(PART_IDENTIFIER)
) checks (
   .clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
   .wbAdr(wbAdr), .wbDatOut(wbDatOut), .wbAck(wbAck), .usbIdPinIn(usbIdPinIn),
   .usbModuleDisable(usbModuleDisable), .usbIdPinOwner(usbIdPinOwner),
   .usbIdPinToUsb(usbIdPinToUsb), .usbIdPinToPort(usbIdPinToPort),
   .userValueField(userValueField)
);

// ==== bench/device_config_and_id_regs_tb.sv ====
// self-checking bench for the configuration and id register bank
`timescale 1ns/10ps
module device_config_and_id_regs_tb;
   localparam [31:0] CFG_WORD = 32'hEDFF_A5C3;
   localparam [31:0] SERIAL0 = 32'h1234_5678;
   localparam [31:0] SERIAL1 = 32'h9ABC_DEF0;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg wbCyc = 1'b0;
   reg wbStb = 1'b0;
   reg wbWe = 1'b0;
   reg [7:0] wbAdr = 8'h00;
   reg [31:0] wbDatIn = 32'h0000_0000;
   reg usbModuleDisable = 1'b0;
   reg usbIdPinIn = 1'b0;
   wire [31:0] wbDatOut;
   wire [15:0] userValueField;
   wire wbAck, usbIdPinOwner, ethernetPinSetSelect, mediaInterfaceSelect;
   wire pinRemapLocked, moduleDisableLocked, permGroupLocked, usbIdPinToUsb, usbIdPinToPort;
   wire noAltPinSet;
   reg [31:0] rdat;
   integer miscompares = 0;
   integer checks = 0;
   integer i, pass;
   device_config_and_id_regs uut (
      .clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(4'hF), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .nvConfigWordThree(CFG_WORD), .nvSerialWord0(SERIAL0), .nvSerialWord1(SERIAL1),
      .usbModuleDisable(usbModuleDisable), .usbIdPinIn(usbIdPinIn),
      .usbIdPinOwner(usbIdPinOwner), .ethernetPinSetSelect(ethernetPinSetSelect),
      .mediaInterfaceSelect(mediaInterfaceSelect), .userValueField(userValueField),
      .pinRemapLocked(pinRemapLocked), .moduleDisableLocked(moduleDisableLocked),
      .permGroupLocked(permGroupLocked), .usbIdPinToUsb(usbIdPinToUsb),
      .usbIdPinToPort(usbIdPinToPort)
   );
   // variant without alternate ethernet pins, bus idle
   device_config_and_id_regs #(
      .HAS_ALT_ETHERNET_PINS(0)
   ) uutNoAlt (
      .clk_sys(clk_sys), .rst(rst), .wbCyc(1'b0), .wbStb(1'b0), .wbWe(1'b0),
      .wbAdr(8'h00), .wbSel(4'h0), .wbDatIn(32'h0000_0000), .wbDatOut(), .wbAck(),
      .nvConfigWordThree(CFG_WORD), .nvSerialWord0(SERIAL0), .nvSerialWord1(SERIAL1),
      .usbModuleDisable(1'b0), .usbIdPinIn(1'b0), .usbIdPinOwner(),
      .ethernetPinSetSelect(noAltPinSet), .mediaInterfaceSelect(), .userValueField(),
      .pinRemapLocked(), .moduleDisableLocked(), .permGroupLocked(),
      .usbIdPinToUsb(), .usbIdPinToPort()
   );
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task check(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; read data is taken at the edge that sees ack
   task wb(input we, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_sys);
         wbCyc <= 1'b1;
         wbStb <= 1'b1;
         wbWe <= we;
         wbAdr <= a;
         wbDatIn <= d;
         n = 0;
         @(posedge clk_sys);
         while (wbAck !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk_sys);
         end
         if (n == 20)
            miscompares = miscompares + 1;
         rdat = wbDatOut;
         wbCyc <= 1'b0;
         wbStb <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         wb(1'b0, a, 32'h0000_0000);
         check(rdat, e);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (1000) @(posedge clk_sys);
      miscompares = miscompares + 1;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      // second pass reads back after writes of all ones to every word
      for (pass = 0; pass < 2; pass = pass + 1) begin
         rd(8'h00, CFG_WORD);
         rd(8'h04, 32'h1000_0001);
         rd(8'h08, SERIAL0);
         rd(8'h0C, SERIAL1);
         for (i = 0; i < 4; i = i + 1)
            wb(1'b1, {i[5:0], 2'b00}, 32'hFFFF_FFFF);
      end
      rd(8'h20, 32'h0000_0000);
      check({usbIdPinOwner, mediaInterfaceSelect, ethernetPinSetSelect}, 32'h0000_0006);
      check(userValueField, 32'h0000_A5C3);
      check({noAltPinSet, ethernetPinSetSelect}, 32'h0000_0002);
      rd(8'h10, 32'h0000_0000);
      for (i = 0; i < 2; i = i + 1) begin
         wb(1'b1, 8'h14, 32'h0000_0007);
         check({permGroupLocked, moduleDisableLocked, pinRemapLocked}, 32'h0000_0005);
      end
      rd(8'h10, 32'h0000_0005);
      usbIdPinIn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check({usbIdPinToUsb, usbIdPinToPort}, 32'h0000_0002);
      usbModuleDisable <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check({usbIdPinToUsb, usbIdPinToPort}, 32'h0000_0001);
      print_verdict;
   end
endmodule
